// ### inc/ext_irq_params.svh
// Purpose: Constants of the external interrupt front end
// Assumes: Byte-wide registers on a 16-bit address
// Notes:   Definitions only
`ifndef EXT_IRQ_PARAMS_SVH
`define EXT_IRQ_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define EIRQ_CTL1_ADDR   16'h0fd8
`define EIRQ_CTL4_ADDR   16'h0fdb
`define EIRQ_GATE_ADDR   16'h0f80
`define EIRQ_STAT_ADDR   16'h0f81
`define EIRQ_MASK_ADDR   16'h0f82

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define EIRQ_LVL_BIT     4
`define EIRQ_GATE_BIT    0
`define EIRQ_CTL_RESET   5'h00
`define EIRQ_GATE_RESET  1'h0
`define EIRQ_MASK_RESET  6'h00

// ------------------------------------------------------------
// Operating modes and trigger codes
// ------------------------------------------------------------
`define EIRQ_MODE_FAST   2'h0
`define EIRQ_MODE_SLOW   2'h1
`define EIRQ_ES_RISE     2'h0
`define EIRQ_ES_FALL     2'h1
`define EIRQ_ES_BOTH     2'h2
`define EIRQ_ES_HIGH     2'h3

// ------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------
`define EIRQ_NC_MASK0    4'h0
`define EIRQ_NC_MASK1    4'h3
`define EIRQ_NC_MASK2    4'h7
`define EIRQ_NC_MASK3    4'hf
`define EIRQ_LS_DIV_LAST 2'h3

`endif

// ### inc/ext_irq_pkg.sv
// Purpose: Types of the external interrupt front end
// Assumes: Six sources, four of them configurable
// Notes:   Constants live in ext_irq_params.svh
`default_nettype none

package ext_irq_pkg;

    typedef struct packed {
        logic       lvl;
        logic [1:0] es;
        logic [1:0] nc;
    } ctrl_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    typedef struct packed {
        ctrl_t [4:1]      ctl;
        logic             gate;
        logic [5:0]       mask;
        logic [5:0]       stat;
        logic [5:0]       sync1;
        logic [5:0]       sync2;
        logic [5:0]       filt;
        logic [5:0][1:0]  hist;
        logic [3:0]       pre;
        logic [1:0]       lsdiv;
        logic [7:0]       rdata;
        logic             irq;
    } state_t;

endpackage

`default_nettype wire

// ### verilog/ext_irq_filter.sv
// Purpose: Six-pin external interrupt noise filter and trigger detector
// Assumes: MODE and LS_TICK come from logic on CLK
// Notes:   Read data stand one cycle after the read strobe
//
// What this block does
// - Source four: rise, fall, both, high level
// - Sources one-three: rise, fall, both; 11 reserved
// - Level flag takes filtered level per request
// - Interval field picks gear divide 1,4,8,16
// - Fast modes: sources one-four need three equal samples to accept level
// - Fast modes: short pulses rejected, long accepted
// - Slow modes: all sources same pulse limits
// - Source zero: falling edge, two-cycle filter
// - Sources zero and five fixed, others programmable
// - Gate bit off stops filters and requests
// - Rewrites and mode changes may raise requests
// - Control bits 7-5 zero, level read-only
// - Slow modes: low clock div 4, two samples
// - Stop modes: sampling frozen, only source four high level requests
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_params.svh"

module ext_irq_filter
    import ext_irq_pkg::*;
(
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RESET_N,
    // Register port
    input  wire bus_req_t   BUS,
    output logic [7:0]      RDATA,
    // Operating mode and low-speed tick
    input  wire logic [1:0] MODE,
    input  wire logic       LS_TICK,
    // Interrupt pins, sources 0 and 5 active low
    input  wire logic [5:0] EXT_IRQ_PIN,
    // Interrupt output
    output logic            IRQ
);

    state_t     q;
    state_t     next_q;
    logic [5:0] req;
    logic       fast;
    logic       slow;
    logic       ls_tick;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic       fixed;
        logic       tick;
        logic       rise;
        logic       fall;
        logic [1:0] es;
        logic [1:0] nc;
        logic [3:0] ncm;
        next_q = q;
        req = 6'h00;
        fixed = 1'b0;
        tick = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        es = 2'h0;
        nc = 2'h0;
        ncm = 4'h0;
        fast = (MODE == `EIRQ_MODE_FAST);
        slow = (MODE == `EIRQ_MODE_SLOW);
        ls_tick = 1'b0;
        next_q.sync1 = EXT_IRQ_PIN;
        next_q.sync2 = q.sync1;

        // Software writes come first so hardware capture wins
        if (BUS.wr) begin
            for (int k = 1; k <= 4; k++) begin
                if (BUS.addr == `EIRQ_CTL1_ADDR + 16'(k - 1)) begin
                    next_q.ctl[k].es = BUS.wdata[3:2];
                    next_q.ctl[k].nc = BUS.wdata[1:0];
                end
            end
            if (BUS.addr == `EIRQ_GATE_ADDR)
                next_q.gate = BUS.wdata[`EIRQ_GATE_BIT];
            if (BUS.addr == `EIRQ_MASK_ADDR)
                next_q.mask = BUS.wdata[5:0];
        end

        if (!q.gate) begin
            // Held low so turning the clock on makes no edge
            next_q.pre = 4'h0;
            next_q.lsdiv = 2'h0;
            next_q.hist = '0;
            next_q.filt = 6'h00;
        end else begin
            if (fast)
                next_q.pre = q.pre + 4'h1;
            if (slow && LS_TICK)
                next_q.lsdiv = q.lsdiv + 2'h1;
            ls_tick = slow && LS_TICK && (q.lsdiv == `EIRQ_LS_DIV_LAST);
            for (int i = 0; i < 6; i++) begin
                fixed = (i == 0) || (i == 5);
                nc = fixed ? 2'h0 : q.ctl[(i < 1 || i > 4) ? 1 : i].nc;
                es = fixed ? `EIRQ_ES_FALL : q.ctl[(i < 1 || i > 4) ? 1 : i].es;
                case (nc)
                    2'h0: ncm = `EIRQ_NC_MASK0;
                    2'h1: ncm = `EIRQ_NC_MASK1;
                    2'h2: ncm = `EIRQ_NC_MASK2;
                    default: ncm = `EIRQ_NC_MASK3;
                endcase
                // Stop modes leave tick low, freezing history
                tick = fast ? ((q.pre & ncm) == 4'h0) : ls_tick;
                if (tick) begin
                    next_q.hist[i] = {q.hist[i][0], q.sync2[i]};
                    if (fast && !fixed) begin
                        if (q.sync2[i] == q.hist[i][0] && q.hist[i][0] == q.hist[i][1])
                            next_q.filt[i] = q.sync2[i];
                    end else if (q.sync2[i] == q.hist[i][0]) begin
                        next_q.filt[i] = q.sync2[i];
                    end
                end
                rise = next_q.filt[i] & ~q.filt[i];
                fall = ~next_q.filt[i] & q.filt[i];
                // No edge suppression on rewrites or mode changes
                case (es)
                    `EIRQ_ES_RISE: req[i] = rise;
                    `EIRQ_ES_FALL: req[i] = fall;
                    `EIRQ_ES_BOTH: req[i] = rise | fall;
                    `EIRQ_ES_HIGH: req[i] = (i == 4) && next_q.filt[i];
                    default: req[i] = 1'b0;
                endcase
            end
            for (int k = 1; k <= 4; k++) begin
                if (req[k])
                    next_q.ctl[k].lvl = next_q.filt[k];
            end
        end

        // ------------------------------------------------------------
        // Sticky status, set beats clear
        // ------------------------------------------------------------
        if (BUS.wr && BUS.addr == `EIRQ_STAT_ADDR)
            next_q.stat = q.stat & ~BUS.wdata[5:0];
        next_q.stat = next_q.stat | req;
        next_q.irq = |(next_q.stat & next_q.mask);

        // ------------------------------------------------------------
        // Read data, one cycle later
        // ------------------------------------------------------------
        next_q.rdata = 8'h00;
        if (BUS.rd) begin
            for (int k = 1; k <= 4; k++) begin
                if (BUS.addr == `EIRQ_CTL1_ADDR + 16'(k - 1))
                    next_q.rdata = {3'h0, q.ctl[k]};
            end
            case (BUS.addr)
                `EIRQ_GATE_ADDR: next_q.rdata = {7'h00, q.gate};
                `EIRQ_STAT_ADDR: next_q.rdata = {2'h0, q.stat};
                `EIRQ_MASK_ADDR: next_q.rdata = {2'h0, q.mask};
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            q <= '0;
            q.ctl <= {4{`EIRQ_CTL_RESET}};
            q.gate <= `EIRQ_GATE_RESET;
            q.mask <= `EIRQ_MASK_RESET;
        end else begin
            q <= next_q;
        end
    end

    assign RDATA = q.rdata;
    assign IRQ = q.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_gate_off;
        @(posedge CLK) disable iff (!RESET_N)
        !q.gate |=> (q.filt == 6'h00) && (q.hist == '0);
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("filter not cleared while gated");

    property p_three_samples;
        @(posedge CLK) disable iff (!RESET_N)
        q.gate && fast && (q.filt[1] != next_q.filt[1])
            |-> (q.sync2[1] == q.hist[1][0]) && (q.hist[1][0] == q.hist[1][1]);
    endproperty
    a_three_samples: assert property (p_three_samples) else $error("source 1 accepted too early");

    property p_level_capture;
        @(posedge CLK) disable iff (!RESET_N)
        req[4] |=> q.ctl[4].lvl == q.filt[4];
    endproperty
    a_level_capture: assert property (p_level_capture) else $error("level flag not captured");

    property p_high_level;
        @(posedge CLK) disable iff (!RESET_N)
        q.gate && q.ctl[4].es == `EIRQ_ES_HIGH && q.filt[4] && next_q.filt[4] |=> q.stat[4];
    endproperty
    a_high_level: assert property (p_high_level) else $error("high level gave no request");

    property p_reserved;
        @(posedge CLK) disable iff (!RESET_N)
        !((q.ctl[1].es == `EIRQ_ES_HIGH && req[1]) ||
          (q.ctl[2].es == `EIRQ_ES_HIGH && req[2]) ||
          (q.ctl[3].es == `EIRQ_ES_HIGH && req[3]));
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code raised request");

    property p_src0_fall;
        @(posedge CLK) disable iff (!RESET_N)
        q.gate && fast && q.filt[0] && !q.sync2[0] && !q.hist[0][0] |=> !q.filt[0] ##0 q.stat[0];
    endproperty
    a_src0_fall: assert property (p_src0_fall) else $error("source 0 fall missed");

    property p_reg_read;
        @(posedge CLK) disable iff (!RESET_N)
        BUS.rd && BUS.addr == `EIRQ_CTL4_ADDR |=> RDATA == {3'h0, $past(q.ctl[4])};
    endproperty
    a_reg_read: assert property (p_reg_read) else $error("control read wrong");

    property p_stop_freeze;
        @(posedge CLK) disable iff (!RESET_N)
        q.gate && !fast && !slow |=> $stable(q.filt) && $stable(q.hist);
    endproperty
    a_stop_freeze: assert property (p_stop_freeze) else $error("sampling ran in stop mode");

    property p_interval;
        @(posedge CLK) disable iff (!RESET_N)
        q.gate && fast && q.ctl[3].nc == 2'h1 && (next_q.hist[3] != q.hist[3]) |-> q.pre[1:0] == 2'h0;
    endproperty
    a_interval: assert property (p_interval) else $error("source 3 sampled off interval");

    property p_slow_rate;
        @(posedge CLK) disable iff (!RESET_N)
        q.gate && slow && (next_q.hist[5] != q.hist[5]) |-> LS_TICK && q.lsdiv == `EIRQ_LS_DIV_LAST;
    endproperty
    a_slow_rate: assert property (p_slow_rate) else $error("slow sampling off divide by 4");

    property p_gate_hold;
        @(posedge CLK) disable iff (!RESET_N)
        !q.gate |=> (q.pre == 4'h0) && (q.lsdiv == 2'h0);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("dividers ran while gated");

    property p_gate_quiet;
        @(posedge CLK) disable iff (!RESET_N)
        !q.gate |-> (req == 6'h00);
    endproperty
    a_gate_quiet: assert property (p_gate_quiet) else $error("request while gated");

    property p_rise_src1;
        @(posedge CLK) disable iff (!RESET_N)
        q.gate && q.ctl[1].es == `EIRQ_ES_RISE |-> req[1] == (next_q.filt[1] && !q.filt[1]);
    endproperty
    a_rise_src1: assert property (p_rise_src1) else $error("source 1 rise request wrong");

    property p_rise_src4;
        @(posedge CLK) disable iff (!RESET_N)
        q.gate && q.ctl[4].es == `EIRQ_ES_RISE |-> req[4] == (next_q.filt[4] && !q.filt[4]);
    endproperty
    a_rise_src4: assert property (p_rise_src4) else $error("source 4 rise request wrong");

    property p_fall_src4;
        @(posedge CLK) disable iff (!RESET_N)
        q.gate && q.ctl[4].es == `EIRQ_ES_FALL |-> req[4] == (!next_q.filt[4] && q.filt[4]);
    endproperty
    a_fall_src4: assert property (p_fall_src4) else $error("source 4 fall request wrong");

    property p_both_src4;
        @(posedge CLK) disable iff (!RESET_N)
        q.gate && q.ctl[4].es == `EIRQ_ES_BOTH |-> req[4] == (next_q.filt[4] != q.filt[4]);
    endproperty
    a_both_src4: assert property (p_both_src4) else $error("source 4 both-edge request wrong");

    property p_fixed_fall;
        @(posedge CLK) disable iff (!RESET_N)
        q.gate |-> (req[0] == (q.filt[0] && !next_q.filt[0]))
            && (req[5] == (q.filt[5] && !next_q.filt[5]));
    endproperty
    a_fixed_fall: assert property (p_fixed_fall) else $error("fixed source not falling edge");

    property p_src0_two;
        @(posedge CLK) disable iff (!RESET_N)
        q.gate && fast && (q.filt[0] != next_q.filt[0]) |-> q.sync2[0] == q.hist[0][0];
    endproperty
    a_src0_two: assert property (p_src0_two) else $error("source 0 accepted on one sample");

    property p_three_src4;
        @(posedge CLK) disable iff (!RESET_N)
        q.gate && fast && (q.filt[4] != next_q.filt[4])
            |-> (q.sync2[4] == q.hist[4][0]) && (q.hist[4][0] == q.hist[4][1]);
    endproperty
    a_three_src4: assert property (p_three_src4) else $error("source 4 accepted too early");

    property p_interval_nc3;
        @(posedge CLK) disable iff (!RESET_N)
        q.gate && fast && q.ctl[1].nc == 2'h3 && (next_q.hist[1] != q.hist[1]) |-> q.pre == 4'h0;
    endproperty
    a_interval_nc3: assert property (p_interval_nc3) else $error("source 1 sampled off divide by 16");

    property p_slow_two;
        @(posedge CLK) disable iff (!RESET_N)
        q.gate && slow && (q.filt[5] != next_q.filt[5]) |-> ls_tick && (q.sync2[5] == q.hist[5][0]);
    endproperty
    a_slow_two: assert property (p_slow_two) else $error("slow accept off tick or sample pair");

    property p_slow_no_pre;
        @(posedge CLK) disable iff (!RESET_N)
        q.gate && slow |=> $stable(q.pre);
    endproperty
    a_slow_no_pre: assert property (p_slow_no_pre) else $error("gear divider ran in slow mode");

    property p_stop_quiet;
        @(posedge CLK) disable iff (!RESET_N)
        q.gate && !fast && !slow && q.ctl[4].es != `EIRQ_ES_HIGH |-> req == 6'h00;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("edge request in stop mode");

    property p_lvl_readonly;
        @(posedge CLK) disable iff (!RESET_N)
        BUS.wr && BUS.addr == `EIRQ_CTL4_ADDR && !req[4] |=> q.ctl[4].lvl == $past(q.ctl[4].lvl);
    endproperty
    a_lvl_readonly: assert property (p_lvl_readonly) else $error("level flag took a write");

    property p_ctl_write;
        @(posedge CLK) disable iff (!RESET_N)
        BUS.wr && BUS.addr == `EIRQ_CTL4_ADDR |=> {q.ctl[4].es, q.ctl[4].nc} == $past(BUS.wdata[3:0]);
    endproperty
    a_ctl_write: assert property (p_ctl_write) else $error("control fields not written");

    property p_lvl_src1;
        @(posedge CLK) disable iff (!RESET_N)
        req[1] |=> q.ctl[1].lvl == q.filt[1];
    endproperty
    a_lvl_src1: assert property (p_lvl_src1) else $error("source 1 level flag not captured");

endmodule

`default_nettype wire

// ### bench/ext_irq_source.sv
// Purpose: Model of the six external interrupt sources
// Assumes: Pins 0 and 5 idle high, the others idle low
// Notes:   Pulses last whole gear cycles
`timescale 1ns/1ps
`default_nettype none

module ext_irq_source (
    // Clock
    input  wire logic  CLK,
    // Pins
    output logic [5:0] PIN
);
    localparam logic [5:0] IDLE = 6'h21;

    initial PIN = IDLE;

    // ----------------------------------------
    // Drive helpers
    // ----------------------------------------
    task automatic level(input int idx, input logic act);
        @(posedge CLK);
        PIN[idx] <= act ? ~IDLE[idx] : IDLE[idx];
    endtask

    task automatic pulse(input int idx, input int n);
        level(idx, 1'b1);
        repeat (n - 1) @(posedge CLK);
        level(idx, 1'b0);
    endtask
endmodule

`default_nettype wire

// ### bench/ext_irq_noise_filter_detect_bench.sv
// Purpose: Self-checking bench of the external interrupt filter
// Assumes: Low-speed clock period is four gear cycles
// Notes:   Status is cleared after every control or mode change
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_params.svh"

module ext_irq_noise_filter_detect_bench;
    import ext_irq_pkg::*;

    logic       CLK = 1'b0;
    logic       RESET_N = 1'b0;
    logic       LS_TICK = 1'b0;
    logic [1:0] MODE = 2'h0;
    bus_req_t   BUS = '0;
    logic [7:0] RDATA;
    logic       IRQ;
    logic [5:0] PIN;
    logic [7:0] rv;
    logic [1:0] lsc = 2'h0;
    int         p;
    int         n_errors = 0;
    int         tests_run = 0;

    always #12.5 CLK = ~CLK;

    always @(posedge CLK) begin
        lsc <= lsc + 2'h1;
        LS_TICK <= (lsc == 2'h3);
    end

    ext_irq_filter dut (.CLK(CLK), .RESET_N(RESET_N), .BUS(BUS), .RDATA(RDATA),
                        .MODE(MODE), .LS_TICK(LS_TICK), .EXT_IRQ_PIN(PIN), .IRQ(IRQ));
    ext_irq_source src (.CLK(CLK), .PIN(PIN));

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge CLK);
        BUS <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge CLK);
        BUS.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge CLK);
        BUS <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge CLK);
        BUS.rd <= 1'b0;
        #1 chk(RDATA, exp);
    endtask

    task automatic wait_clr(input int n);
        repeat (n) @(posedge CLK);
        wr(`EIRQ_STAT_ADDR, 8'h3f);
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge CLK);
        n_errors++;
        stop_test();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge CLK);
        RESET_N <= 1'b1;
        rchk(`EIRQ_GATE_ADDR, 8'h00);
        src.pulse(0, 6);
        repeat (10) @(posedge CLK);
        rchk(`EIRQ_STAT_ADDR, 8'h00);
        wr(`EIRQ_GATE_ADDR, 8'h01);
        wait_clr(8);
        rchk(`EIRQ_STAT_ADDR, 8'h00);
        rchk(`EIRQ_CTL4_ADDR, 8'h00);
        wr(`EIRQ_CTL4_ADDR, 8'hff);
        rchk(`EIRQ_CTL4_ADDR, 8'h0f);
        rchk(16'h0123, 8'h00);
        wr(`EIRQ_MASK_ADDR, 8'h3f);
        wait_clr(8);
        $display("test registers done");
        src.pulse(0, 3);
        repeat (6) @(posedge CLK);
        rchk(`EIRQ_STAT_ADDR, 8'h01);
        chk({7'h0, IRQ}, 8'h01);
        wr(`EIRQ_MASK_ADDR, 8'h3e);
        @(posedge CLK);
        #1 chk({7'h0, IRQ}, 8'h00);
        wr(`EIRQ_STAT_ADDR, 8'h01);
        rchk(`EIRQ_STAT_ADDR, 8'h00);
        wr(`EIRQ_MASK_ADDR, 8'h3f);
        $display("test source zero done");
        // Short pulse dies, long one passes, at every interval
        for (int nc = 0; nc < 4; nc++) begin
            p = (nc == 0) ? 1 : (2 << nc);
            wr(`EIRQ_CTL1_ADDR, {6'h0, 2'(nc)});
            wait_clr(4 * p + 4);
            src.pulse(1, 2 * p - 1);
            repeat (4 * p + 4) @(posedge CLK);
            rchk(`EIRQ_STAT_ADDR, 8'h00);
            src.pulse(1, 3 * p + 2);
            repeat (4 * p + 4) @(posedge CLK);
            rchk(`EIRQ_STAT_ADDR, 8'h02);
            rchk(`EIRQ_CTL1_ADDR, {4'h1, 2'h0, 2'(nc)});
        end
        wr(`EIRQ_CTL1_ADDR, 8'h0c);
        wait_clr(8);
        src.pulse(1, 8);
        repeat (10) @(posedge CLK);
        rchk(`EIRQ_STAT_ADDR, 8'h00);
        $display("test filter fast done");
        for (int es = 0; es < 4; es++) begin
            wr(`EIRQ_CTL4_ADDR, {4'h0, 2'(es), 2'h0});
            wait_clr(6);
            src.level(4, 1'b1);
            repeat (8) @(posedge CLK);
            rchk(`EIRQ_STAT_ADDR, {3'h0, 1'(4'b1101 >> es), 4'h0});
            wr(`EIRQ_STAT_ADDR, 8'h10);
            src.level(4, 1'b0);
            repeat (8) @(posedge CLK);
            rchk(`EIRQ_STAT_ADDR, {3'h0, 1'(4'b1110 >> es), 4'h0});
            rchk(`EIRQ_CTL4_ADDR, {3'h0, 1'(4'b1001 >> es), 2'(es), 2'h0});
        end
        $display("test source four done");
        // Source 2 both edges, source 3 falling edge at divide by 4
        wr(`EIRQ_CTL1_ADDR + 16'h0001, 8'h08);
        wr(`EIRQ_CTL1_ADDR + 16'h0002, 8'h05);
        wait_clr(8);
        src.level(2, 1'b1);
        src.pulse(3, 16);
        repeat (8) @(posedge CLK);
        rchk(`EIRQ_CTL1_ADDR + 16'h0001, 8'h18);
        src.level(2, 1'b0);
        repeat (8) @(posedge CLK);
        rchk(`EIRQ_CTL1_ADDR + 16'h0001, 8'h08);
        rchk(`EIRQ_STAT_ADDR, 8'h0c);
        rchk(`EIRQ_CTL1_ADDR + 16'h0002, 8'h05);
        wr(`EIRQ_STAT_ADDR, 8'h3f);
        $display("test sources two three done");
        @(posedge CLK);
        MODE <= `EIRQ_MODE_SLOW;
        wait_clr(60);
        src.pulse(5, 15);
        repeat (40) @(posedge CLK);
        rchk(`EIRQ_STAT_ADDR, 8'h00);
        src.pulse(5, 36);
        repeat (40) @(posedge CLK);
        rchk(`EIRQ_STAT_ADDR, 8'h20);
        @(posedge CLK);
        MODE <= 2'h2;
        wait_clr(8);
        src.pulse(0, 40);
        repeat (40) @(posedge CLK);
        rchk(`EIRQ_STAT_ADDR, 8'h00);
        $display("test slow and stop done");
        // Reset in mid-run brings back the gated state
        @(posedge CLK);
        RESET_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RESET_N <= 1'b1;
        rchk(`EIRQ_GATE_ADDR, 8'h00);
        rchk(`EIRQ_CTL4_ADDR, 8'h00);
        rchk(`EIRQ_STAT_ADDR, 8'h00);
        $display("test reset again done");
        stop_test();
    end
endmodule

`default_nettype wire
